// ### src/oam_cfg.svh
// Purpose: offsets, field values, reset values and limits of the OAM remote-command and counter bank
// Assumes: register index times four is the AXI4-Lite byte address
// Notes:   definitions only
`ifndef OAM_CFG_SVH
`define OAM_CFG_SVH

// register indices
`define IDX_CNT_CLEAR     10'h044
`define IDX_OP_MODE       10'h04a
`define IDX_RC_ADDR       10'h04b
`define IDX_RC_DATA       10'h04c
`define IDX_SENT_CNT      10'h04d
`define IDX_RECV_CNT      10'h04e
`define IDX_STATUS_COPY   10'h04f

// field positions
`define OP_MODE_HI        1
`define OP_MODE_LO        0

// field codes and values
`define OP_MODE_NORMAL    2'h0
`define OP_MODE_EXTENDED  2'h2
`define CNT_CLEAR_VALUE   8'h00

// reset values
`define RST_OP_MODE       2'h2
`define RST_RC_BYTE       8'h00
`define RST_COUNT         8'h00
`define RST_COPY_TERMINAL 8'h07
`define RST_COPY_CENTER   8'h47

// limits and timing
`define COUNT_MAX         8'hff
`define STRAP_WAIT        2'h2

// bus answers
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ### src/oam_pkg.sv
// Purpose: types shared by the OAM remote-command and counter bank
// Assumes: constants come from oam_cfg.svh
// Notes:   types only
`include "oam_cfg.svh"

package oam_pkg;
    typedef logic [7:0]  byte_t;
    typedef logic [11:0] addr_t;
    typedef logic [9:0]  index_t;
    typedef logic [31:0] word_t;
    typedef logic [1:0]  resp_t;
    typedef logic [1:0]  opmode_t;
endpackage : oam_pkg

// ### src/oam_remote_cmd_counters.sv
// Purpose: remote-command bytes, maintenance-frame counters and partner status copy, AXI4-Lite slave
// Assumes: frame and status inputs come from logic on clk; the side strap comes from a pin
// Notes:   byte address of each register is its index times four; data in bits 7:0
//
// Function
// - central-side remote command puts address byte at bits 39..32
// - extended mode: address byte is target register
// - central-side remote command puts data byte at bits 47..40
// - extended mode: data byte is operation value
// - count valid sent frames from zero, holding at 255
// - count received frames with good CRC, opcode, direction
// - writing zero to clear register zeroes counters
// - subscriber side: copy tracks status while link up
// - central side: copy loads status after power-on, link up
// - central side: copy kept over warm reset, power-down
// - central side: tracking resumes after first link return
// - mode 10 extended, mode 00 normal
`timescale 1ns/1ns
`default_nettype none
`include "oam_cfg.svh"

module oam_remote_cmd_counters (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rstn,
    // axi4-lite write address
    input  wire oam_pkg::addr_t awaddr,
    input  wire logic           awvalid,
    output logic                awready,
    // axi4-lite write data
    input  wire oam_pkg::word_t wdata,
    input  wire logic [3:0]     wstrb,
    input  wire logic           wvalid,
    output logic                wready,
    // axi4-lite write response
    output oam_pkg::resp_t      bresp,
    output logic                bvalid,
    input  wire logic           bready,
    // axi4-lite read address
    input  wire oam_pkg::addr_t araddr,
    input  wire logic           arvalid,
    output logic                arready,
    // axi4-lite read data
    output oam_pkg::word_t      rdata,
    output oam_pkg::resp_t      rresp,
    output logic                rvalid,
    input  wire logic           rready,
    // side strap pin, high for subscriber side
    input  wire logic           subscriberSide,
    // frame assembly
    input  wire logic           frameLoad,
    input  wire logic           remoteCmd,
    input  wire oam_pkg::byte_t modelInfo2,
    input  wire oam_pkg::byte_t modelInfo3,
    output oam_pkg::byte_t      frameBits39to32,
    output oam_pkg::byte_t      frameBits47to40,
    output logic                extendedMode,
    // frame events
    input  wire logic           frameSentValid,
    input  wire logic           frameRxDone,
    input  wire logic           frameRxCrcOk,
    input  wire logic           frameRxOpValid,
    input  wire logic           frameRxDirValid,
    // partner status and link state
    input  wire oam_pkg::byte_t partnerStatus,
    input  wire logic           opticalLinkUp,
    input  wire logic           warmReset,
    input  wire logic           chipPowerDown,
    output logic                sideKnown
);
    import oam_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state
    byte_t   rcAddr_q;
    byte_t   rcData_q;
    opmode_t opMode_q;
    byte_t   sentCnt_q;
    byte_t   recvCnt_q;
    byte_t   copy_q;
    byte_t   frame2_q;
    byte_t   frame3_q;
    logic    strapSync1_q;
    logic    strapSync2_q;
    logic    isSub_q;
    logic    sideKnown_q;
    logic [1:0] strapCnt_q;
    logic    holdCopy_q;
    logic    linkSeen_q;
    logic    awHave_q;
    index_t  awIdx_q;
    logic    wHave_q;
    byte_t   wByte_q;
    logic    wLane0_q;
    logic    bvalid_q;
    resp_t   bresp_q;
    logic    rvalid_q;
    word_t   rdata_q;
    resp_t   rresp_q;

    // decoded write effects
    logic    doWrite;
    logic    wrAddr;
    logic    wrData;
    logic    wrMode;
    logic    wrClear;
    logic    wrMapped;
    logic    cntClear;
    logic    rxGood;
    logic    useRemote;
    logic    centerSide;

    ////////////////////////////////////////////////////////////////////////////
    // bus handshakes
    assign awready = !awHave_q && !bvalid_q;
    assign wready  = !wHave_q && !bvalid_q;
    assign arready = !rvalid_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;
    assign doWrite = awHave_q && wHave_q && !bvalid_q;

    // write address holding
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            awHave_q <= 1'b0;
            awIdx_q  <= 10'h000;
        end else if (awvalid && awready) begin
            awHave_q <= 1'b1;
            awIdx_q  <= awaddr[11:2];
        end else if (doWrite) begin
            awHave_q <= 1'b0;
        end
    end

    // write data holding
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wHave_q  <= 1'b0;
            wByte_q  <= 8'h00;
            wLane0_q <= 1'b0;
        end else if (wvalid && wready) begin
            wHave_q  <= 1'b1;
            wByte_q  <= wdata[7:0];
            wLane0_q <= wstrb[0];
        end else if (doWrite) begin
            wHave_q <= 1'b0;
        end
    end

    // write address decode
    always_comb begin
        wrAddr   = 1'b0;
        wrData   = 1'b0;
        wrMode   = 1'b0;
        wrClear  = 1'b0;
        wrMapped = 1'b1;
        if (awIdx_q == `IDX_RC_ADDR) begin
            wrAddr = doWrite && wLane0_q;
        end else if (awIdx_q == `IDX_RC_DATA) begin
            wrData = doWrite && wLane0_q;
        end else if (awIdx_q == `IDX_OP_MODE) begin
            wrMode = doWrite && wLane0_q;
        end else if (awIdx_q == `IDX_CNT_CLEAR) begin
            wrClear = doWrite && wLane0_q;
        end else if (awIdx_q == `IDX_SENT_CNT || awIdx_q == `IDX_RECV_CNT
                     || awIdx_q == `IDX_STATUS_COPY) begin
            wrMapped = 1'b1; // read-only, write ignored
        end else begin
            wrMapped = 1'b0;
        end
    end

    // write response
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `RESP_OKAY;
        end else if (doWrite) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // read data, registered one cycle after the address is taken
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rresp_q  <= `RESP_OKAY;
            rdata_q  <= 32'h00000000;
            if (araddr[11:2] == `IDX_RC_ADDR) begin
                rdata_q[7:0] <= rcAddr_q;
            end else if (araddr[11:2] == `IDX_RC_DATA) begin
                rdata_q[7:0] <= rcData_q;
            end else if (araddr[11:2] == `IDX_OP_MODE) begin
                rdata_q[1:0] <= opMode_q;
            end else if (araddr[11:2] == `IDX_CNT_CLEAR) begin
                rdata_q[7:0] <= 8'h00; // clear register reads zero
            end else if (araddr[11:2] == `IDX_SENT_CNT) begin
                rdata_q[7:0] <= sentCnt_q;
            end else if (araddr[11:2] == `IDX_RECV_CNT) begin
                rdata_q[7:0] <= recvCnt_q;
            end else if (araddr[11:2] == `IDX_STATUS_COPY) begin
                rdata_q[7:0] <= copy_q;
            end else begin
                rresp_q <= `RESP_SLVERR;
            end
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // side strap: two-flop synchroniser, then caught once after reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strapSync1_q <= 1'b0;
            strapSync2_q <= 1'b0;
        end else begin
            strapSync1_q <= subscriberSide;
            strapSync2_q <= strapSync1_q;
        end
    end

    // strap capture waits until the synchroniser holds the pin value
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strapCnt_q  <= 2'h0;
            sideKnown_q <= 1'b0;
            isSub_q     <= 1'b0;
        end else if (!sideKnown_q) begin
            if (strapCnt_q == `STRAP_WAIT) begin
                sideKnown_q <= 1'b1;
                isSub_q     <= strapSync2_q;
            end else begin
                strapCnt_q <= strapCnt_q + 2'h1;
            end
        end
    end

    assign sideKnown  = sideKnown_q;
    assign centerSide = sideKnown_q && !isSub_q;

    ////////////////////////////////////////////////////////////////////////////
    // software-owned bytes and mode field
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rcAddr_q <= `RST_RC_BYTE;
            rcData_q <= `RST_RC_BYTE;
            opMode_q <= `RST_OP_MODE;
        end else begin
            if (wrAddr) begin
                rcAddr_q <= wByte_q;
            end
            if (wrData) begin
                rcData_q <= wByte_q;
            end
            if (wrMode) begin
                opMode_q <= wByte_q[`OP_MODE_HI:`OP_MODE_LO];
            end
        end
    end

    // mode 10 maps the command bytes into the frame
    assign extendedMode = (opMode_q == `OP_MODE_EXTENDED);

    ////////////////////////////////////////////////////////////////////////////
    // frame bytes, sampled only at frame load
    assign useRemote = (remoteCmd && centerSide) || extendedMode;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frame2_q <= 8'h00;
            frame3_q <= 8'h00;
        end else if (frameLoad) begin
            // target register address in extended mode
            frame2_q <= useRemote ? rcAddr_q : modelInfo2;
            // operation data value in extended mode
            frame3_q <= useRemote ? rcData_q : modelInfo3;
        end
    end

    assign frameBits39to32 = frame2_q;
    assign frameBits47to40 = frame3_q;

    ////////////////////////////////////////////////////////////////////////////
    // frame counters; an event in the clear cycle still counts
    assign cntClear = wrClear && (wByte_q == `CNT_CLEAR_VALUE);
    assign rxGood   = frameRxDone && frameRxCrcOk && frameRxOpValid && frameRxDirValid;

    // transmitted valid frames
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sentCnt_q <= `RST_COUNT;
        end else if (cntClear) begin
            sentCnt_q <= frameSentValid ? 8'h01 : `RST_COUNT;
        end else if (frameSentValid && sentCnt_q != `COUNT_MAX) begin
            sentCnt_q <= sentCnt_q + 8'h01;
        end
    end

    // received valid frames
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            recvCnt_q <= `RST_COUNT;
        end else if (cntClear) begin
            recvCnt_q <= rxGood ? 8'h01 : `RST_COUNT;
        end else if (rxGood && recvCnt_q != `COUNT_MAX) begin
            recvCnt_q <= recvCnt_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // central side hold: warm reset or power-down freezes the copy
    // until the link has come back once, so the old partner status
    // is what software sees at the first return
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            holdCopy_q <= 1'b0;
            linkSeen_q <= 1'b0;
        end else if (centerSide && (warmReset || chipPowerDown)) begin
            holdCopy_q <= 1'b1;
            linkSeen_q <= 1'b0;
        end else if (holdCopy_q && opticalLinkUp) begin
            if (linkSeen_q) begin
                holdCopy_q <= 1'b0;
            end
            linkSeen_q <= 1'b1;
        end
    end

    // status copy; power-on default follows the caught side
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            copy_q <= 8'h00;
        end else if (!sideKnown_q) begin
            if (strapCnt_q == `STRAP_WAIT) begin
                copy_q <= strapSync2_q ? `RST_COPY_TERMINAL : `RST_COPY_CENTER;
            end
        end else if (isSub_q) begin
            if (opticalLinkUp) begin
                copy_q <= partnerStatus;
            end
        end else if (!holdCopy_q && opticalLinkUp) begin
            copy_q <= partnerStatus;
        end
    end

endmodule : oam_remote_cmd_counters
`default_nettype wire

// ### sim/oam_remote_cmd_counters_asserts.sv
// Purpose: port checks for the OAM command bank
// Assumes: one clock, rstn async active low
// Notes:   bound to every instance of the design
`timescale 1ns/1ns
`default_nettype none
`include "oam_cfg.svh"

module oam_remote_cmd_counters_asserts (
    // clock and reset
    input wire logic           clk,
    input wire logic           rstn,
    // register bus
    input wire logic           awvalid,
    input wire logic           awready,
    input wire logic           wvalid,
    input wire logic           wready,
    input wire logic           bvalid,
    input wire logic           arvalid,
    input wire logic           arready,
    input wire logic           rvalid,
    input wire oam_pkg::addr_t araddr,
    input wire oam_pkg::word_t rdata,
    input wire oam_pkg::resp_t rresp,
    // frame assembly
    input wire logic           frameLoad,
    input wire logic           remoteCmd,
    input wire logic           extendedMode,
    input wire oam_pkg::byte_t modelInfo2,
    input wire oam_pkg::byte_t modelInfo3,
    input wire oam_pkg::byte_t frameBits39to32,
    input wire oam_pkg::byte_t frameBits47to40
);
    import oam_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    index_t rdIdx;
    logic   rdMapped;
    // register index of a read and whether it names a register
    assign rdIdx = araddr[11:2];
    assign rdMapped = rdIdx == `IDX_CNT_CLEAR || (rdIdx >= `IDX_OP_MODE && rdIdx <= `IDX_STATUS_COPY);
    ////////////////////////////////////////
    // handshake steps
    sequence s_arTake; arvalid && arready; endsequence
    sequence s_wrTake; awvalid && awready && wvalid && wready; endsequence
    sequence s_normalLoad; frameLoad && !remoteCmd && !extendedMode; endsequence
    a_read_answer: assert property (s_arTake |=> rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_wrTake |=> !bvalid ##1 bvalid)
        else $error("write response timing wrong");
    a_write_refuse: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    a_read_unmapped: assert property (s_arTake ##0 !rdMapped |=> rresp == `RESP_SLVERR && rdata == 32'h0)
        else $error("unmapped read not refused");
    a_read_mapped: assert property (s_arTake ##0 rdMapped |=> rresp == `RESP_OKAY && rdata[31:8] == 24'h0)
        else $error("mapped read answer wrong");
    a_mode_flag: assert property (s_arTake ##0 rdIdx == `IDX_OP_MODE
        |=> extendedMode == (rdata[1:0] == `OP_MODE_EXTENDED)) else $error("mode flag disagrees");
    a_frame_normal: assert property (s_normalLoad
        |=> frameBits39to32 == $past(modelInfo2) && frameBits47to40 == $past(modelInfo3))
        else $error("normal frame bytes wrong");
    a_frame_hold: assert property (!frameLoad
        |=> $stable(frameBits39to32) && $stable(frameBits47to40)) else $error("frame bytes moved");
endmodule : oam_remote_cmd_counters_asserts

bind oam_remote_cmd_counters oam_remote_cmd_counters_asserts chk_u (.*);
`default_nettype wire

// ### sim/oam_link_partner.sv
// Purpose: far-side model feeding frame events, status and link
// Assumes: bench orders arrive on clk
// Notes:   status line toggles while the link is down
`timescale 1ns/1ns
`default_nettype none

module oam_link_partner (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rstn,
    // orders from the bench
    input  wire logic           txGo,
    input  wire logic           rxGo,
    input  wire logic [2:0]     rxFlags,
    input  wire logic           linkGo,
    input  wire oam_pkg::byte_t statusIn,
    // lines towards the block
    output logic                frameSentValid,
    output logic                frameRxDone,
    output logic                frameRxCrcOk,
    output logic                frameRxOpValid,
    output logic                frameRxDirValid,
    output oam_pkg::byte_t      partnerStatus,
    output logic                opticalLinkUp
);
    import oam_pkg::*;
    // frame events and link one cycle behind the orders
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {frameSentValid, frameRxDone, frameRxCrcOk, frameRxOpValid, frameRxDirValid, opticalLinkUp} <= 6'h0;
        end else begin
            {frameSentValid, frameRxDone, opticalLinkUp} <= {txGo, rxGo, linkGo};
            {frameRxCrcOk, frameRxOpValid, frameRxDirValid} <= rxFlags;
        end
    end
    // status is only meaningful with the link up
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) partnerStatus <= 8'h5a;
        else partnerStatus <= linkGo ? statusIn : ~partnerStatus;
    end
endmodule : oam_link_partner
`default_nettype wire

// ### sim/oam_remote_cmd_counters_test.sv
// Purpose: self-checking bench for the OAM command bank
// Assumes: partner model drives frame events and link
// Notes:   notes of expected results queue up, a monitor compares
`timescale 1ns/1ns
`default_nettype none
`include "oam_cfg.svh"

module oam_remote_cmd_counters_test;
    import oam_pkg::*;
    logic        clk = 1'b0, rstn = 1'b0, subscriberSide = 1'b0, flPend = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
    logic        frameLoad = 1'b0, remoteCmd = 1'b0, txGo = 1'b0, rxGo = 1'b0, linkGo = 1'b0;
    logic        warmReset = 1'b0, chipPowerDown = 1'b0;
    logic [3:0]  wstrb = 4'hf;
    logic [2:0]  rxFlags = 3'h7;
    addr_t       awaddr = 12'h0, araddr = 12'h0;
    word_t       wdata = 32'h0, rdata;
    byte_t       modelInfo2 = 8'h0, modelInfo3 = 8'h0, statusIn = 8'h0, frameBits39to32, frameBits47to40;
    byte_t       partnerStatus, cmdA, cmdD, m2, m3, s1;
    resp_t       bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, extendedMode, sideKnown, opticalLinkUp;
    logic        frameSentValid, frameRxDone, frameRxCrcOk, frameRxOpValid, frameRxDirValid;
    logic [33:0] rdQ[$], bQ[$], fQ[$];
    int          err_total = 0, checks = 0, cyc = 0;
    integer      seed = 32'hb77b0723;

    oam_remote_cmd_counters dut_u (.*);
    oam_link_partner link_u (.*);
    // 250 MHz clock
    always #2 clk = ~clk;
    ////////////////////////////////////////
    function automatic addr_t ba(input index_t i);
        return {i, 2'h0};
    endfunction : ba
    task cmp(input string nm, input logic [33:0] e, input logic [33:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task wr(input addr_t a, input byte_t d, input resp_t r);
        awaddr <= a;
        wdata <= {24'($random(seed)), d};
        {awvalid, wvalid} <= 2'h3;
        bQ.push_back({32'h0, r});
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        do @(posedge clk); while (!bvalid);
    endtask : wr
    task rd(input addr_t a, input resp_t r, input byte_t v);
        araddr <= a;
        arvalid <= 1'b1;
        rdQ.push_back({r, 24'h0, v});
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
    endtask : rd
    task frame(input logic rc, input logic [15:0] e);
        {modelInfo2, modelInfo3, remoteCmd, frameLoad} <= {m2, m3, rc, 1'b1};
        fQ.push_back({18'h0, e});
        @(posedge clk);
        frameLoad <= 1'b0;
        @(posedge clk);
    endtask : frame
    task ev(input logic tx, input logic rx, input logic [2:0] fl, input int n);
        {txGo, rxGo, rxFlags} <= {tx, rx, fl};
        repeat (n) @(posedge clk);
        {txGo, rxGo} <= 2'h0;
        repeat (2) @(posedge clk);
    endtask : ev
    task link_up(input logic up, input byte_t s, input int n);
        {linkGo, statusIn} <= {up, s};
        repeat (n) @(posedge clk);
    endtask : link_up
    task reset_to(input logic sub);
        {rstn, subscriberSide, linkGo} <= {1'b0, sub, 1'b0};
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        do @(posedge clk); while (!sideKnown);
    endtask : reset_to
    task complete_run;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////
    // monitor: oldest note against each result seen
    always @(posedge clk) begin
        if (rvalid && rready) cmp("read", rdQ.pop_front(), {rresp, rdata});
        if (bvalid && bready) cmp("bresp", bQ.pop_front(), {32'h0, bresp});
        if (flPend) cmp("frame", fQ.pop_front(), {18'h0, frameBits47to40, frameBits39to32});
        flPend <= frameLoad;
    end
    // watchdog against a hang
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            complete_run();
        end
    end
    // main sequence
    initial begin
        reset_to(1'b0);
        rd(ba(`IDX_RC_ADDR), `RESP_OKAY, `RST_RC_BYTE);
        rd(ba(`IDX_RC_DATA), `RESP_OKAY, `RST_RC_BYTE);
        rd(ba(`IDX_RECV_CNT), `RESP_OKAY, `RST_COUNT);
        rd(ba(`IDX_STATUS_COPY), `RESP_OKAY, `RST_COPY_CENTER);
        rd(ba(`IDX_OP_MODE), `RESP_OKAY, {6'h0, `RST_OP_MODE});
        rd(12'h140, `RESP_SLVERR, 8'h0);
        wr(12'h120, 8'h5, `RESP_SLVERR);
        wr(ba(`IDX_SENT_CNT), 8'h33, `RESP_OKAY);
        rd(ba(`IDX_SENT_CNT), `RESP_OKAY, `RST_COUNT);
        $display("test defaults done");
        {cmdA, cmdD, m2, m3} = $random(seed);
        wr(ba(`IDX_RC_ADDR), cmdA, `RESP_OKAY);
        wr(ba(`IDX_RC_DATA), cmdD, `RESP_OKAY);
        rd(ba(`IDX_RC_ADDR), `RESP_OKAY, cmdA);
        rd(ba(`IDX_RC_DATA), `RESP_OKAY, cmdD);
        // byte lane 0 off: the write is answered but must not land
        wstrb <= 4'he;
        wr(ba(`IDX_RC_ADDR), ~cmdA, `RESP_OKAY);
        wstrb <= 4'hf;
        rd(ba(`IDX_RC_ADDR), `RESP_OKAY, cmdA);
        frame(1'b0, {cmdD, cmdA});
        wr(ba(`IDX_OP_MODE), {6'h0, `OP_MODE_NORMAL}, `RESP_OKAY);
        frame(1'b0, {m3, m2});
        frame(1'b1, {cmdD, cmdA});
        $display("test frames done");
        ev(1'b1, 1'b0, 3'h7, 3);
        ev(1'b0, 1'b1, 3'h7, 2);
        for (int i = 0; i < 3; i++) ev(1'b0, 1'b1, 3'h7 ^ (3'h1 << i), 1);
        rd(ba(`IDX_SENT_CNT), `RESP_OKAY, 8'h3);
        rd(ba(`IDX_RECV_CNT), `RESP_OKAY, 8'h2);
        wr(ba(`IDX_CNT_CLEAR), 8'h1, `RESP_OKAY);
        rd(ba(`IDX_SENT_CNT), `RESP_OKAY, 8'h3);
        ev(1'b1, 1'b1, 3'h7, 260);
        rd(ba(`IDX_SENT_CNT), `RESP_OKAY, `COUNT_MAX);
        rd(ba(`IDX_RECV_CNT), `RESP_OKAY, `COUNT_MAX);
        wr(ba(`IDX_CNT_CLEAR), `CNT_CLEAR_VALUE, `RESP_OKAY);
        rd(ba(`IDX_SENT_CNT), `RESP_OKAY, 8'h0);
        rd(ba(`IDX_RECV_CNT), `RESP_OKAY, 8'h0);
        $display("test counters done");
        for (int i = 0; i < 2; i++) begin
            s1 = 8'($random(seed));
            link_up(1'b1, s1, 4);
            rd(ba(`IDX_STATUS_COPY), `RESP_OKAY, s1);
            link_up(1'b0, s1, 2);
            {chipPowerDown, warmReset} <= 2'(i + 1);
            @(posedge clk);
            {chipPowerDown, warmReset} <= 2'h0;
            link_up(1'b1, ~s1, 2);
            rd(ba(`IDX_STATUS_COPY), `RESP_OKAY, s1);
            repeat (3) @(posedge clk);
            rd(ba(`IDX_STATUS_COPY), `RESP_OKAY, ~s1);
        end
        $display("test central copy done");
        reset_to(1'b1);
        rd(ba(`IDX_STATUS_COPY), `RESP_OKAY, `RST_COPY_TERMINAL);
        wr(ba(`IDX_OP_MODE), {6'h0, `OP_MODE_NORMAL}, `RESP_OKAY);
        frame(1'b1, {m3, m2});
        // a reserved mode code is stored but does not select the command bytes
        wr(ba(`IDX_OP_MODE), 8'h3, `RESP_OKAY);
        rd(ba(`IDX_OP_MODE), `RESP_OKAY, 8'h3);
        frame(1'b0, {m3, m2});
        link_up(1'b1, s1, 4);
        rd(ba(`IDX_STATUS_COPY), `RESP_OKAY, s1);
        warmReset <= 1'b1;
        @(posedge clk);
        warmReset <= 1'b0;
        link_up(1'b1, ~s1, 2);
        rd(ba(`IDX_STATUS_COPY), `RESP_OKAY, ~s1);
        $display("test subscriber copy done");
        complete_run();
    end
endmodule : oam_remote_cmd_counters_test
`default_nettype wire
